//--- sleep_policy_pkg.sv
package sleep_policy_pkg;

   // register map
   localparam logic [7:0] KEEP_RES_ON_OFFSET = 8'h42;
   localparam logic [7:0] LDO_SLEEP_OFF_OFFSET = 8'h43;
   localparam logic [7:0] KEEP_RES_ON_RESET = 8'h00;
   localparam logic [7:0] LDO_SLEEP_OFF_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
   // bit 3 of the keep register is reserved and reads zero
   localparam logic [7:0] KEEP_WRITABLE_MASK = 8'hF7;

   // keep register field positions
   localparam int THERMAL_KEEP_BIT = 7;
   localparam int SLOW_CLOCK_KEEP_BIT = 6;
   localparam int RTC_REGULATOR_KEEP_BIT = 5;
   localparam int FAST_CLOCK_KEEP_BIT = 4;
   localparam int CORE_BUCK_B_KEEP_BIT = 2;
   localparam int CORE_BUCK_A_KEEP_BIT = 1;
   localparam int IO_BUCK_KEEP_BIT = 0;

   // sleep-off bit i drives regulator number LDO_NUMBER[i]
   localparam int NUM_LDO = 8;
   localparam int NUM_BUCK = 3;
   localparam int NUM_SUPPLY = NUM_LDO + NUM_BUCK;
   localparam logic [NUM_LDO-1:0][3:0] LDO_NUMBER = {
      4'h3, 4'h4, 4'h7, 4'h8, 4'h5, 4'h2, 4'h1, 4'h6};

   // supply state field: bit0 set means on, bit1 set means low power
   localparam int SUPPLY_ON_POS = 0;
   localparam int SUPPLY_LOW_POS = 1;

   typedef enum logic {
      POWER_ACTIVE,
      POWER_SLEEP
   } power_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic thermal_en;
      logic slow_clock_en;
      logic rtc_full_load;
      logic fast_clock_en;
      logic [NUM_BUCK-1:0] buck_pwm;
      logic [NUM_BUCK-1:0] buck_off;
      logic [NUM_LDO-1:0] ldo_off;
      logic sleeping;
   } policy_s;

   typedef struct packed {
      power_state_e fsm;
      logic [7:0] keep;
      logic [7:0] ldo_sleep_off;
      logic [7:0] on_entry;
      logic [NUM_BUCK-1:0] pwm_entry;
      policy_s out;
      logic [7:0] rdata;
      logic rvalid;
   } ctrl_state_s;

   typedef struct packed {
      logic first;
      logic second;
   } sync_state_s;

   localparam policy_s OUT_RESET = '{
      thermal_en: 1'b1, slow_clock_en: 1'b1, rtc_full_load: 1'b1, fast_clock_en: 1'b1,
      buck_pwm: 3'h0, buck_off: 3'h0, ldo_off: 8'h00, sleeping: 1'b0};

   localparam ctrl_state_s CTRL_RESET = '{
      fsm: POWER_ACTIVE, keep: KEEP_RES_ON_RESET, ldo_sleep_off: LDO_SLEEP_OFF_RESET,
      on_entry: 8'h00, pwm_entry: 3'h0, out: OUT_RESET, rdata: 8'h00, rvalid: 1'b0};

   localparam sync_state_s SYNC_RESET = '{first: 1'b0, second: 1'b0};

endpackage

//--- sleep_req_sync.sv
`timescale 1ns/10ps
module sleep_req_sync
   import sleep_policy_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   // pin side
   input wire logic ASYNC_IN,
   // clock domain side
   output logic SYNC_OUT
);
   sync_state_s st;
   sync_state_s next_st;

   // first stage feeds only the second stage
   always_comb begin
      next_st.first = ASYNC_IN;
      next_st.second = st.first;
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         st <= SYNC_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign SYNC_OUT = st.second;
endmodule

//--- sleep_state_resource_policy.sv
`timescale 1ns/10ps
// Functional notes
// R01: The thermal-keep bit keeps die thermal monitoring on during sleep, else it is off.
// R02: The slow-clock-keep bit keeps the 32 kHz output running in sleep, else it is held low.
// R03: The rtc-regulator-keep bit keeps full load in sleep, else the regulator is low power.
// R04: The fast-clock-keep bit keeps the high-speed clock running in sleep, else it stops.
// R05: Bit 2 keeps core buck b in PWM during sleep, else PFM, with no effect if already PFM.
// R06: Bit 1 keeps core buck a in PWM during sleep, else PFM, with no effect if already PFM.
// R07: Bit 0 keeps the io buck in PWM during sleep, else PFM, with no effect if already PFM.
// R08: A keep bit does nothing for a resource that is already off when sleep is entered.
// R09: In sleep a programmed supply state field overrides the keep setting of its resource.
// R10: Each set sleep-off bit turns its regulator off in sleep, mapped as LDO 3,4,7,8,5,2,1,6.
// R11: A sleep-off bit acts only while its matching keep-on bit is clear.
// R12: The sleep request pin is active high when the polarity bit is 1, active low when 0.
// R13: Settings apply on sleep entry and all resources return to full operation on wake.
module sleep_state_resource_policy
   import sleep_policy_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic SYS_RST_IN,
   // register access from the serial port controller
   input wire reg_req_s REG_REQ_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   // sleep request pin and its polarity configuration
   input wire logic SLEEP_REQ_PIN_IN,
   input wire logic SLEEP_POL_IN,
   // resource status, same bit layout as the keep register; LDO keep-on bits match the sleep-off register
   input wire logic [7:0] RES_ON_IN,
   input wire logic [NUM_BUCK-1:0] BUCK_PWM_IN,
   input wire logic [NUM_LDO-1:0] LDO_KEEP_ON_IN,
   // supply state fields, LDO bits first then bucks io, a, b
   input wire logic [NUM_SUPPLY-1:0] SUPPLY_OVR_VALID_IN,
   input wire logic [NUM_SUPPLY-1:0][1:0] SUPPLY_STATE_IN,
   // resource controls
   output policy_s POLICY_OUT
);
   ctrl_state_s st;
   ctrl_state_s next_st;
   logic sleep_sync;
   logic sleep_req;
   logic [NUM_BUCK-1:0] buck_pwm_sleep;
   logic [NUM_BUCK-1:0] buck_off_sleep;
   logic [NUM_LDO-1:0] ldo_off_sleep;

   sleep_req_sync sleep_req_sync_inst (
      .CLK_SYS_IN(CLK_SYS_IN),
      .SYS_RST_IN(SYS_RST_IN),
      .ASYNC_IN(SLEEP_REQ_PIN_IN),
      .SYNC_OUT(sleep_sync)
   );

   // polarity is a register bit on our clock, so no sync is needed
   assign sleep_req = SLEEP_POL_IN ? sleep_sync : !sleep_sync; // R12

   for (genvar i = 0; i < NUM_BUCK; i++) begin : g_buck
      logic field_on;
      logic field_full;
      assign field_on = SUPPLY_STATE_IN[NUM_LDO+i][SUPPLY_ON_POS];
      assign field_full = field_on && !SUPPLY_STATE_IN[NUM_LDO+i][SUPPLY_LOW_POS];
      // without an override, pwm only if kept, on at entry and in pwm at entry
      assign buck_pwm_sleep[i] = SUPPLY_OVR_VALID_IN[NUM_LDO+i] ? field_full : // R09
         (st.keep[i] && st.on_entry[i] && st.pwm_entry[i]); // R05 R06 R07 R08
      assign buck_off_sleep[i] = SUPPLY_OVR_VALID_IN[NUM_LDO+i] && !field_on; // R09
   end

   for (genvar i = 0; i < NUM_LDO; i++) begin : g_ldo
      assign ldo_off_sleep[i] = SUPPLY_OVR_VALID_IN[i] ?
         !SUPPLY_STATE_IN[i][SUPPLY_ON_POS] : // R09
         (st.ldo_sleep_off[i] && !LDO_KEEP_ON_IN[i]); // R10 R11
   end

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      if (REG_REQ_IN.wr) begin
         case (REG_REQ_IN.addr)
            KEEP_RES_ON_OFFSET: next_st.keep = REG_REQ_IN.wdata & KEEP_WRITABLE_MASK;
            LDO_SLEEP_OFF_OFFSET: next_st.ldo_sleep_off = REG_REQ_IN.wdata;
            default: ;
         endcase
      end
      if (REG_REQ_IN.rd) begin
         next_st.rvalid = 1'b1;
         case (REG_REQ_IN.addr)
            KEEP_RES_ON_OFFSET: next_st.rdata = st.keep;
            LDO_SLEEP_OFF_OFFSET: next_st.rdata = st.ldo_sleep_off;
            default: next_st.rdata = UNMAPPED_READ_VALUE;
         endcase
      end
      case (st.fsm)
         POWER_ACTIVE: begin
            if (sleep_req) begin
               next_st.fsm = POWER_SLEEP; // R13
               // snapshot on entry; later changes in sleep cannot revive a keep
               next_st.on_entry = RES_ON_IN & KEEP_WRITABLE_MASK; // R08
               next_st.pwm_entry = BUCK_PWM_IN; // R05 R06 R07
            end
         end
         POWER_SLEEP: begin
            if (!sleep_req) begin
               next_st.fsm = POWER_ACTIVE; // R13
            end
         end
         default: next_st.fsm = POWER_ACTIVE;
      endcase
      if (st.fsm == POWER_SLEEP) begin
         next_st.out.thermal_en = st.keep[THERMAL_KEEP_BIT] &&
            st.on_entry[THERMAL_KEEP_BIT]; // R01 R08
         next_st.out.slow_clock_en = st.keep[SLOW_CLOCK_KEEP_BIT] &&
            st.on_entry[SLOW_CLOCK_KEEP_BIT]; // R02 R08
         next_st.out.rtc_full_load = st.keep[RTC_REGULATOR_KEEP_BIT] &&
            st.on_entry[RTC_REGULATOR_KEEP_BIT]; // R03 R08
         next_st.out.fast_clock_en = st.keep[FAST_CLOCK_KEEP_BIT] &&
            st.on_entry[FAST_CLOCK_KEEP_BIT]; // R04 R08
         next_st.out.buck_pwm = buck_pwm_sleep;
         next_st.out.buck_off = buck_off_sleep;
         next_st.out.ldo_off = ldo_off_sleep;
         next_st.out.sleeping = 1'b1;
      end else begin
         // awake: full load, clocks and monitoring; bucks follow their own mode
         next_st.out.thermal_en = 1'b1; // R13
         next_st.out.slow_clock_en = 1'b1;
         next_st.out.rtc_full_load = 1'b1;
         next_st.out.fast_clock_en = 1'b1;
         next_st.out.buck_pwm = BUCK_PWM_IN;
         next_st.out.buck_off = '0;
         next_st.out.ldo_off = '0;
         next_st.out.sleeping = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         st <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign POLICY_OUT = st.out;
   assign REG_RDATA_OUT = st.rdata;
   assign REG_RVALID_OUT = st.rvalid;

   // checks
   logic armed;
   always_ff @(posedge CLK_SYS_IN) begin
      armed <= !SYS_RST_IN;
   end

   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (SYS_RST_IN);

   AST_THERMAL_SLEEP: assert property ( // R01
      armed && $past(st.fsm) == POWER_SLEEP |->
      POLICY_OUT.thermal_en == ($past(st.keep[7]) && $past(st.on_entry[7])))
      else $error("thermal enable wrong in sleep");

   AST_SLOW_CLOCK_SLEEP: assert property ( // R02
      armed && $past(st.fsm) == POWER_SLEEP && !$past(st.keep[6]) |->
      !POLICY_OUT.slow_clock_en)
      else $error("slow clock not held low in sleep");

   AST_RTC_SLEEP: assert property ( // R03
      armed && $past(st.fsm) == POWER_SLEEP |->
      POLICY_OUT.rtc_full_load == ($past(st.keep[5]) && $past(st.on_entry[5])))
      else $error("rtc load mode wrong in sleep");

   AST_FAST_CLOCK_SLEEP: assert property ( // R04
      armed && $past(st.fsm) == POWER_SLEEP |->
      POLICY_OUT.fast_clock_en == ($past(st.keep[4]) && $past(st.on_entry[4])))
      else $error("fast clock wrong in sleep");

   AST_BUCK_B_PWM: assert property ( // R05
      armed && $past(st.fsm) == POWER_SLEEP && !$past(SUPPLY_OVR_VALID_IN[10]) |->
      POLICY_OUT.buck_pwm[2] == ($past(st.keep[2]) && $past(st.on_entry[2]) &&
      $past(st.pwm_entry[2])))
      else $error("core buck b mode wrong in sleep");

   AST_BUCK_A_PFM: assert property ( // R06
      armed && $past(st.fsm) == POWER_SLEEP && !$past(SUPPLY_OVR_VALID_IN[9]) &&
      (!$past(st.keep[1]) || !$past(st.pwm_entry[1])) |-> !POLICY_OUT.buck_pwm[1])
      else $error("core buck a not in pfm in sleep");

   AST_IO_BUCK_PWM: assert property ( // R07
      armed && $past(st.fsm) == POWER_SLEEP && !$past(SUPPLY_OVR_VALID_IN[8]) &&
      $past(st.keep[0]) && $past(st.on_entry[0]) && $past(st.pwm_entry[0]) |->
      POLICY_OUT.buck_pwm[0])
      else $error("io buck left pwm in sleep");

   AST_ENTRY_SNAPSHOT: assert property ( // R08
      st.fsm == POWER_ACTIVE && sleep_req |=>
      st.fsm == POWER_SLEEP && st.on_entry == ($past(RES_ON_IN) & 8'hF7))
      else $error("entry snapshot not taken");

   AST_BUCK_OVERRIDE: assert property ( // R09
      armed && $past(st.fsm) == POWER_SLEEP && $past(SUPPLY_OVR_VALID_IN[9]) &&
      $past(SUPPLY_STATE_IN[9]) == 2'h1 |-> POLICY_OUT.buck_pwm[1] && !POLICY_OUT.buck_off[1])
      else $error("supply state override ignored");

   AST_LDO_SLEEP_OFF: assert property ( // R10 R11
      armed && $past(st.fsm) == POWER_SLEEP && $past(SUPPLY_OVR_VALID_IN[7:0]) == 8'h00 |->
      POLICY_OUT.ldo_off == ($past(st.ldo_sleep_off) & ~$past(LDO_KEEP_ON_IN)))
      else $error("ldo sleep off wrong");

   AST_POLARITY: assert property ( // R12
      st.fsm == POWER_ACTIVE && (SLEEP_POL_IN == sleep_sync) |=> st.fsm == POWER_SLEEP)
      else $error("sleep request polarity not honoured");

   AST_WAKE_RESTORE: assert property ( // R13
      st.fsm == POWER_SLEEP && !sleep_req |=> ##1
      POLICY_OUT.thermal_en && POLICY_OUT.slow_clock_en && POLICY_OUT.rtc_full_load &&
      POLICY_OUT.fast_clock_en && POLICY_OUT.ldo_off == 8'h00 && !POLICY_OUT.sleeping)
      else $error("resources not restored on wake");

   // register port checks
   AST_READ_VALID: assert property ( // R10
      REG_REQ_IN.rd |=> REG_RVALID_OUT)
      else $error("read valid missing");

   AST_VALID_PULSE: assert property ( // R10
      !REG_REQ_IN.rd |=> !REG_RVALID_OUT)
      else $error("read valid longer than one cycle");

   AST_READ_KEEP: assert property ( // R01
      REG_REQ_IN.rd && REG_REQ_IN.addr == KEEP_RES_ON_OFFSET |=>
      REG_RDATA_OUT == $past(st.keep))
      else $error("keep register read wrong");

   AST_READ_SLEEP_OFF: assert property ( // R10
      REG_REQ_IN.rd && REG_REQ_IN.addr == LDO_SLEEP_OFF_OFFSET |=>
      REG_RDATA_OUT == $past(st.ldo_sleep_off))
      else $error("sleep off register read wrong");

   AST_READ_UNMAPPED: assert property ( // R10
      REG_REQ_IN.rd && REG_REQ_IN.addr != KEEP_RES_ON_OFFSET &&
      REG_REQ_IN.addr != LDO_SLEEP_OFF_OFFSET |=> REG_RDATA_OUT == UNMAPPED_READ_VALUE)
      else $error("unmapped read not zero");

   AST_RDATA_HOLD: assert property ( // R10
      !REG_REQ_IN.rd |=> $stable(REG_RDATA_OUT))
      else $error("read data moved without a read");

   AST_KEEP_WRITE: assert property ( // R01
      REG_REQ_IN.wr && REG_REQ_IN.addr == KEEP_RES_ON_OFFSET |=>
      st.keep == ($past(REG_REQ_IN.wdata) & KEEP_WRITABLE_MASK))
      else $error("keep register write lost");

   AST_SLEEP_OFF_WRITE: assert property ( // R10
      REG_REQ_IN.wr && REG_REQ_IN.addr == LDO_SLEEP_OFF_OFFSET |=>
      st.ldo_sleep_off == $past(REG_REQ_IN.wdata))
      else $error("sleep off register write lost");

   AST_CONFIG_HOLD: assert property ( // R10
      !REG_REQ_IN.wr |=> $stable(st.keep) && $stable(st.ldo_sleep_off))
      else $error("configuration changed without a write");

   // awake, sleep and entry checks
   AST_AWAKE_MODE: assert property ( // R13
      armed && $past(st.fsm) == POWER_ACTIVE |->
      POLICY_OUT.buck_pwm == $past(BUCK_PWM_IN) && !POLICY_OUT.sleeping)
      else $error("awake buck mode wrong");

   AST_AWAKE_ON: assert property ( // R13
      armed && $past(st.fsm) == POWER_ACTIVE |-> POLICY_OUT.thermal_en &&
      POLICY_OUT.slow_clock_en && POLICY_OUT.rtc_full_load && POLICY_OUT.fast_clock_en)
      else $error("awake resource not fully on");

   AST_AWAKE_NO_OFF: assert property ( // R13
      armed && $past(st.fsm) == POWER_ACTIVE |->
      POLICY_OUT.buck_off == 3'h0 && POLICY_OUT.ldo_off == 8'h00)
      else $error("supply switched off while awake");

   AST_SLEEPING_FLAG: assert property ( // R13
      armed && $past(st.fsm) == POWER_SLEEP |-> POLICY_OUT.sleeping)
      else $error("sleeping flag missing");

   AST_STAY_ACTIVE: assert property ( // R12
      st.fsm == POWER_ACTIVE && !sleep_req |=> st.fsm == POWER_ACTIVE)
      else $error("sleep entered without a request");

   AST_STAY_ASLEEP: assert property ( // R08
      st.fsm == POWER_SLEEP && sleep_req |=>
      st.fsm == POWER_SLEEP && $stable(st.on_entry) && $stable(st.pwm_entry))
      else $error("entry snapshot moved during sleep");

   // pin passes both flops before use
   AST_SYNC_TWO_FLOPS: assert property ( // R12
      armed && $past(armed) |-> sleep_sync == $past(SLEEP_REQ_PIN_IN, 2))
      else $error("sleep pin synchroniser depth wrong");

   // override checks
   AST_BUCK_OFF_ONLY_OVR: assert property ( // R09
      armed && $past(st.fsm) == POWER_SLEEP && $past(SUPPLY_OVR_VALID_IN[10:8]) == 3'h0 |->
      POLICY_OUT.buck_off == 3'h0)
      else $error("buck off without a programmed state");

   AST_IO_BUCK_OFF: assert property ( // R09
      armed && $past(st.fsm) == POWER_SLEEP && $past(SUPPLY_OVR_VALID_IN[8]) &&
      !$past(SUPPLY_STATE_IN[8][SUPPLY_ON_POS]) |->
      POLICY_OUT.buck_off[0] && !POLICY_OUT.buck_pwm[0])
      else $error("io buck programmed off not honoured");

   AST_LDO_OVERRIDE: assert property ( // R09
      armed && $past(st.fsm) == POWER_SLEEP && $past(SUPPLY_OVR_VALID_IN[7]) |->
      POLICY_OUT.ldo_off[7] == !$past(SUPPLY_STATE_IN[7][SUPPLY_ON_POS]))
      else $error("ldo programmed state not honoured");

   // keep checks on the other polarity of bits 1, 0 and 6
   AST_BUCK_A_KEPT: assert property ( // R06
      armed && $past(st.fsm) == POWER_SLEEP && !$past(SUPPLY_OVR_VALID_IN[9]) &&
      $past(st.keep[1]) && $past(st.on_entry[1]) && $past(st.pwm_entry[1]) |->
      POLICY_OUT.buck_pwm[1])
      else $error("core buck a left pwm in sleep");

   AST_IO_BUCK_PFM: assert property ( // R07
      armed && $past(st.fsm) == POWER_SLEEP && !$past(SUPPLY_OVR_VALID_IN[8]) &&
      !$past(st.keep[0]) |-> !POLICY_OUT.buck_pwm[0])
      else $error("io buck not in pfm in sleep");

   AST_SLOW_CLOCK_KEPT: assert property ( // R02
      armed && $past(st.fsm) == POWER_SLEEP && $past(st.keep[6]) |->
      POLICY_OUT.slow_clock_en == $past(st.on_entry[6]))
      else $error("slow clock not kept in sleep");
endmodule

//--- sleep_state_resource_policy_test.sv
`timescale 1ns/10ps
module sleep_state_resource_policy_test
   import sleep_policy_pkg::*;
;
   logic clk;
   logic rst;
   reg_req_s req;
   logic [7:0] rdata;
   logic rvalid;
   logic pin;
   logic pol;
   logic [7:0] res_on;
   logic [NUM_BUCK-1:0] pwm;
   logic [NUM_LDO-1:0] ldo_keep;
   logic [NUM_SUPPLY-1:0] ovr;
   logic [NUM_SUPPLY-1:0][1:0] st;
   policy_s pout;
   policy_s e;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;

   sleep_state_resource_policy sleep_state_resource_policy_inst (
      .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REG_REQ_IN(req), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .SLEEP_REQ_PIN_IN(pin), .SLEEP_POL_IN(pol),
      .RES_ON_IN(res_on), .BUCK_PWM_IN(pwm), .LDO_KEEP_ON_IN(ldo_keep),
      .SUPPLY_OVR_VALID_IN(ovr), .SUPPLY_STATE_IN(st), .POLICY_OUT(pout));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end

   task wrap_up();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
      @(negedge clk);
      req = '0;
   endtask

   // valid must stand exactly one cycle
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '0;
      chk({rvalid, rdata}, {1'h1, exp});
      @(negedge clk);
      chk({rvalid, rdata}, {1'h0, exp});
   endtask

   // outputs follow the pin four edges later
   task sleep(input logic active);
      @(negedge clk);
      pin = pol ? active : !active;
      repeat (4) @(negedge clk);
   endtask

   function policy_s awake_exp();
      return '{thermal_en: 1'h1, slow_clock_en: 1'h1, rtc_full_load: 1'h1,
         fast_clock_en: 1'h1, buck_pwm: pwm, buck_off: 3'h0, ldo_off: 8'h00, sleeping: 1'h0};
   endfunction

   function policy_s sleep_exp(input logic [7:0] k, input logic [7:0] off);
      policy_s x;
      x.thermal_en = k[7] & res_on[7];
      x.slow_clock_en = k[6] & res_on[6];
      x.rtc_full_load = k[5] & res_on[5];
      x.fast_clock_en = k[4] & res_on[4];
      x.buck_pwm = k[2:0] & res_on[2:0] & pwm;
      x.buck_off = 3'h0;
      x.ldo_off = off & ~ldo_keep;
      x.sleeping = 1'h1;
      return x;
   endfunction

   initial begin
      rst = 1'h1;
      req = '0;
      pin = 1'h0;
      pol = 1'h1;
      res_on = 8'hFF;
      pwm = 3'h7;
      ldo_keep = 8'h00;
      ovr = '0;
      st = '0;
      repeat (3) @(negedge clk);
      rst = 1'h0;
      repeat (2) @(negedge clk);
      chk(pout, awake_exp());
      rd(8'h42, 8'h00);
      rd(8'h43, 8'h00);
      wr(8'h42, 8'hFF);
      rd(8'h42, 8'hF7);
      wr(8'h43, 8'hA5);
      rd(8'h43, 8'hA5);
      wr(8'h44, 8'h5A);
      rd(8'h44, 8'h00);
      rd(8'h42, 8'hF7);
      // one keep bit at a time, so a swapped field shows up
      for (int i = 0; i < 8; i++) begin
         if (i != 3) begin
            wr(8'h42, 8'h01 << i);
            sleep(1'h1);
            chk(pout, sleep_exp(8'h01 << i, 8'hA5));
            sleep(1'h0);
            chk(pout, awake_exp());
         end
      end
      // resources off at entry, then io and core b bucks already in PFM
      wr(8'h42, 8'hF7);
      res_on = 8'h00;
      sleep(1'h1);
      chk(pout, sleep_exp(8'hF7, 8'hA5));
      sleep(1'h0);
      res_on = 8'hFF;
      pwm = 3'h2;
      sleep(1'h1);
      chk(pout, sleep_exp(8'hF7, 8'hA5));
      sleep(1'h0);
      chk(pout, awake_exp());
      ldo_keep = 8'h0F;
      wr(8'h43, 8'hFF);
      sleep(1'h1);
      chk(pout, sleep_exp(8'hF7, 8'hFF));
      sleep(1'h0);
      // programmed supply fields beat keep and sleep-off
      ldo_keep = 8'h00;
      wr(8'h43, 8'h01);
      wr(8'h42, 8'h00);
      sleep(1'h1);
      ovr = 11'h381;
      st[0] = 2'h1;
      st[7] = 2'h2;
      st[8] = 2'h0;
      st[9] = 2'h1;
      repeat (2) @(negedge clk);
      e = sleep_exp(8'h00, 8'h00);
      e.buck_pwm = 3'h2;
      e.buck_off = 3'h1;
      e.ldo_off = 8'h80;
      chk(pout, e);
      ovr = '0;
      sleep(1'h0);
      // active-low request: the pin lags polarity by two flops, so a short sleep comes first
      @(negedge clk);
      pol = 1'h0;
      pin = 1'h1;
      repeat (4) @(negedge clk);
      chk(pout, awake_exp());
      sleep(1'h1);
      chk(pout, sleep_exp(8'h00, 8'h01));
      sleep(1'h0);
      chk(pout, awake_exp());
      wrap_up();
   end
endmodule
